// *** rtl/usbep0_hs.sv ***
`timescale 1ns/1ns
`default_nettype none

module usbep0_hs
  import usbep0_pkg::*;
(
  // Direction state
  input  wire logic       stall,
  input  wire logic       setup_busy,
  input  wire logic       bm_enable,
  input  wire logic       nak_busy,
  // Chosen answer
  output logic [1:0]      code
);

  // Handshake priority for one direction
  always_comb
  begin
    if (stall)
      code = HS_STALL;
    else if (setup_busy)
      code = HS_NAK;
    else if (!bm_enable)
      code = HS_NAK;
    else if (nak_busy)
      code = HS_NAK;
    else
      code = HS_ACK;
  end

endmodule

`default_nettype wire

// *** rtl/usbep0_pkg.sv ***
package usbep0_pkg;

  // ------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [15:0] IDX_IN_CFG   = 16'hff80;
  localparam logic [15:0] IDX_IN_CNT   = 16'hff81;
  localparam logic [15:0] IDX_OUT_CFG  = 16'hff82;
  localparam logic [15:0] IDX_OUT_CNT  = 16'hff83;
  localparam logic [15:0] IDX_STATUS   = 16'hff84;
  localparam logic [15:0] IDX_MASK     = 16'hff85;

  // ------------------------------------------------------------------
  // Configuration register fields
  // ------------------------------------------------------------------
  localparam int CFG_IE_BIT    = 2;
  localparam int CFG_STALL_BIT = 3;
  localparam int CFG_TOG_BIT   = 5;
  localparam int CFG_BME_BIT   = 7;

  // ------------------------------------------------------------------
  // Count register fields
  // ------------------------------------------------------------------
  localparam int CNT_NAK_BIT   = 7;
  localparam int CNT_W         = 4;
  localparam logic [3:0] CNT_MAX     = 4'h8;
  localparam logic [3:0] CNT_RESET   = 4'h0;
  localparam logic       IN_NAK_RESET  = 1'b1;
  localparam logic       OUT_NAK_RESET = 1'b0;

  // ------------------------------------------------------------------
  // Status and mask fields
  // ------------------------------------------------------------------
  localparam int ST_IN_DONE  = 0;
  localparam int ST_OUT_DONE = 1;
  localparam int ST_SETUP    = 2;
  localparam int ST_W        = 3;
  localparam logic [2:0] ST_RESET   = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ------------------------------------------------------------------
  // Fixed buffer bases
  // ------------------------------------------------------------------
  localparam logic [15:0] IN_BUF_BASE  = 16'hfef8;
  localparam logic [15:0] OUT_BUF_BASE = 16'hfef0;

  // ------------------------------------------------------------------
  // Handshake answers (ACK means data phase for IN)
  // ------------------------------------------------------------------
  localparam logic [1:0] HS_ACK   = 2'h0;
  localparam logic [1:0] HS_NAK   = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  // ------------------------------------------------------------------
  // Bus slave states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } usbep0_bus_t;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

// *** rtl/usbep0_regs.sv ***
// Overview of operation
// - Enabled direction interrupts on transaction completion
// - MCU stall bit answers next transaction STALL
// - Input stall clears on next SETUP
// - Output stall clears after STALL sent
// - Read-only toggle bit shows DATA0/DATA1 state
// - Buffer manager serves only when enabled
// - Input count codes above eight mean eight
// - Input NAK resets high; MCU clears it
// - Input NAK high answers IN with NAK
// - Output count filled by device, read-only
// - Output NAK low accepts next OUT
// - Output NAK high answers OUT with NAK
// - Buffers fixed at FEF8 and FEF0
// - Registers at indexes FF80 through FF85
// - Setup flag NAKs both directions
`timescale 1ns/1ns
`default_nettype none

module usbep0_regs
  import usbep0_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Transaction events from the serial engine
  input  wire logic        tok_setup,
  input  wire logic        tok_in,
  input  wire logic        in_host_ack,
  input  wire logic        tok_out,
  input  wire logic        out_data_ok,
  input  wire logic [3:0]  out_len,
  // Handshake decision to the serial engine
  output logic             hs_valid,
  output logic [1:0]       hs_code,
  output logic             hs_is_in,
  output logic [3:0]       in_len,
  output logic             data_toggle,
  // Buffer manager
  output logic             bm_in_enable,
  output logic             bm_out_enable,
  output logic [15:0]      in_buf_base,
  output logic [15:0]      out_buf_base,
  // Interrupt
  output logic             irq
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  usbep0_bus_t bus_state_reg;
  logic [15:0] wr_idx_reg;
  logic [15:0] rd_idx_reg;
  logic        in_bme_reg;
  logic        in_stall_reg;
  logic        in_ie_reg;
  logic        in_tog_reg;
  logic [3:0]  in_cnt_reg;
  logic        in_nak_reg;
  logic        out_bme_reg;
  logic        out_stall_reg;
  logic        out_ie_reg;
  logic        out_tog_reg;
  logic [3:0]  out_cnt_reg;
  logic        out_nak_reg;
  logic        in_pend_reg;
  logic [2:0]  status_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  status_next;
  logic [1:0]  in_code;
  logic [1:0]  out_code;
  logic        bus_take;
  logic        wr_en;
  logic        wr_in_cfg;
  logic        wr_in_cnt;
  logic        wr_out_cfg;
  logic        wr_out_cnt;
  logic        wr_status;
  logic        wr_mask;
  logic        in_done;
  logic        out_accept;
  logic        out_stall_sent;
  logic [7:0]  rd_byte;
  logic [3:0]  in_len_next;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------

  // Address phase taken and data-phase write strobes
  // index decode
  assign bus_take   = hsel && htrans[1] && hready;
  assign wr_en      = (bus_state_reg == BUS_WR);
  assign wr_in_cfg  = wr_en && (wr_idx_reg == IDX_IN_CFG);
  assign wr_in_cnt  = wr_en && (wr_idx_reg == IDX_IN_CNT);
  assign wr_out_cfg = wr_en && (wr_idx_reg == IDX_OUT_CFG);
  assign wr_out_cnt = wr_en && (wr_idx_reg == IDX_OUT_CNT);
  assign wr_status  = wr_en && (wr_idx_reg == IDX_STATUS);
  assign wr_mask    = wr_en && (wr_idx_reg == IDX_MASK);

  // Bus state: writes have no wait, reads one wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bus_state_reg <= BUS_IDLE;
    else
    begin
      case (bus_state_reg)
        BUS_IDLE,
        BUS_WR:
        begin
          if (bus_take && hwrite)
            bus_state_reg <= BUS_WR;
          else if (bus_take)
            bus_state_reg <= BUS_RD;
          else
            bus_state_reg <= BUS_IDLE;
        end
        BUS_RD:
          bus_state_reg <= BUS_IDLE;
        default:
          bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  // Captured word indexes of the address phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_idx_reg <= 16'h0000;
      rd_idx_reg <= 16'h0000;
    end
    else if (bus_take)
    begin
      wr_idx_reg <= haddr[17:2];
      rd_idx_reg <= haddr[17:2];
    end
  end

  // Read value of the addressed register
  // reserved bits read zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (rd_idx_reg)
      IDX_IN_CFG:
      begin
        rd_byte[CFG_IE_BIT]    = in_ie_reg;
        rd_byte[CFG_STALL_BIT] = in_stall_reg;
        rd_byte[CFG_TOG_BIT]   = in_tog_reg;
        rd_byte[CFG_BME_BIT]   = in_bme_reg;
      end
      IDX_IN_CNT:
      begin
        rd_byte[CNT_W-1:0]     = in_cnt_reg;
        rd_byte[CNT_NAK_BIT]   = in_nak_reg;
      end
      IDX_OUT_CFG:
      begin
        rd_byte[CFG_IE_BIT]    = out_ie_reg;
        rd_byte[CFG_STALL_BIT] = out_stall_reg;
        rd_byte[CFG_TOG_BIT]   = out_tog_reg;
        rd_byte[CFG_BME_BIT]   = out_bme_reg;
      end
      IDX_OUT_CNT:
      begin
        rd_byte[CNT_W-1:0]     = out_cnt_reg;
        rd_byte[CNT_NAK_BIT]   = out_nak_reg;
      end
      IDX_STATUS:
        rd_byte[ST_W-1:0]      = status_reg;
      IDX_MASK:
        rd_byte[ST_W-1:0]      = mask_reg;
      default:
        rd_byte = 8'h00;
    endcase
  end

  // Bus answer: ready, response and read data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= RD_ZERO;
    end
    else
    begin
      hresp <= 1'b0;
      if (bus_state_reg == BUS_RD)
      begin
        hreadyout <= 1'b1;
        hrdata    <= {24'h000000, rd_byte};
      end
      else if (bus_take && !hwrite)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Handshake decision
  // ------------------------------------------------------------------

  // Input direction answer
  usbep0_hs u_in_hs (
    .stall      (in_stall_reg),
    .setup_busy (status_reg[ST_SETUP]),
    .bm_enable  (in_bme_reg),
    .nak_busy   (in_nak_reg),
    .code       (in_code)
  );

  // Output direction answer
  usbep0_hs u_out_hs (
    .stall      (out_stall_reg),
    .setup_busy (status_reg[ST_SETUP]),
    .bm_enable  (out_bme_reg),
    .nak_busy   (out_nak_reg),
    .code       (out_code)
  );

  // Completion events of each direction
  // free buffer takes good OUT data
  assign out_accept     = tok_out && out_data_ok && (out_code == HS_ACK);
  assign out_stall_sent = tok_out && (out_code == HS_STALL);
  assign in_done        = in_pend_reg && in_host_ack;

  // Registered handshake towards the serial engine
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hs_valid    <= 1'b0;
      hs_code     <= HS_NAK;
      hs_is_in    <= 1'b0;
      data_toggle <= 1'b0;
    end
    else
    begin
      hs_valid <= tok_setup || tok_in || tok_out;
      if (tok_setup)
      begin
        hs_code  <= HS_ACK;
        hs_is_in <= 1'b0;
      end
      else if (tok_in)
      begin
        hs_code     <= in_code;
        hs_is_in    <= 1'b1;
        data_toggle <= in_tog_reg;
      end
      else if (tok_out)
      begin
        hs_code     <= (out_data_ok || out_code != HS_ACK) ? out_code : HS_NAK;
        hs_is_in    <= 1'b0;
        data_toggle <= out_tog_reg;
      end
    end
  end

  // IN data phase outstanding until the host acknowledges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      in_pend_reg <= 1'b0;
    else if (tok_setup)
      in_pend_reg <= 1'b0;
    else if (tok_in)
      in_pend_reg <= (in_code == HS_ACK);
    else if (in_host_ack)
      in_pend_reg <= 1'b0;
  end

  assign in_len_next = (in_cnt_reg > CNT_MAX) ? CNT_MAX : in_cnt_reg;

  // Length presented for the IN data phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      in_len <= CNT_RESET;
    else
      in_len <= in_len_next;
  end

  // ------------------------------------------------------------------
  // Input endpoint registers
  // ------------------------------------------------------------------

  // Input configuration written by the MCU
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_bme_reg   <= 1'b0;
      in_ie_reg    <= 1'b0;
      in_stall_reg <= 1'b0;
    end
    else if (wr_in_cfg)
    begin
      in_bme_reg   <= hwdata[CFG_BME_BIT];
      in_ie_reg    <= hwdata[CFG_IE_BIT];
      in_stall_reg <= hwdata[CFG_STALL_BIT];
    end
    else if (tok_setup)
      in_stall_reg <= 1'b0;
  end

  // Input count, NAK set by completion wins over MCU write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_cnt_reg <= CNT_RESET;
      in_nak_reg <= IN_NAK_RESET;
    end
    else
    begin
      if (wr_in_cnt)
        in_cnt_reg <= hwdata[CNT_W-1:0];
      if (in_done)
        in_nak_reg <= 1'b1;
      else if (wr_in_cnt)
        in_nak_reg <= hwdata[CNT_NAK_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Output endpoint registers
  // ------------------------------------------------------------------

  // Output configuration written by the MCU
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_bme_reg   <= 1'b0;
      out_ie_reg    <= 1'b0;
      out_stall_reg <= 1'b0;
    end
    else if (wr_out_cfg)
    begin
      out_bme_reg   <= hwdata[CFG_BME_BIT];
      out_ie_reg    <= hwdata[CFG_IE_BIT];
      out_stall_reg <= hwdata[CFG_STALL_BIT];
    end
    else if (out_stall_sent)
      out_stall_reg <= 1'b0;
  end

  // Output count and NAK, filled by the device
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_cnt_reg <= CNT_RESET;
      out_nak_reg <= OUT_NAK_RESET;
    end
    else if (out_accept)
    begin
      out_cnt_reg <= out_len;
      out_nak_reg <= 1'b1;
    end
    else if (wr_out_cnt)
      out_nak_reg <= hwdata[CNT_NAK_BIT];
  end

  // Data toggles: setup starts DATA1, each completion flips
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_tog_reg  <= 1'b0;
      out_tog_reg <= 1'b0;
    end
    else if (tok_setup)
    begin
      in_tog_reg  <= 1'b1;
      out_tog_reg <= 1'b1;
    end
    else
    begin
      if (in_done)
        in_tog_reg <= ~in_tog_reg;
      if (out_accept)
        out_tog_reg <= ~out_tog_reg;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------

  // Sticky status, event set wins over write-one clear
  always_comb
  begin
    status_next = status_reg;
    if (wr_status)
      status_next = status_reg & ~hwdata[ST_W-1:0];
    if (in_done && in_ie_reg)
      status_next[ST_IN_DONE] = 1'b1;
    if (out_accept && out_ie_reg)
      status_next[ST_OUT_DONE] = 1'b1;
    if (tok_setup)
      status_next[ST_SETUP] = 1'b1;
  end

  // Status and mask registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_reg <= ST_RESET;
      mask_reg   <= MASK_RESET;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= hwdata[ST_W-1:0];
    end
  end

  // Interrupt level from the next status value
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

  // ------------------------------------------------------------------
  // Buffer manager outputs
  // ------------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bm_in_enable  <= 1'b0;
      bm_out_enable <= 1'b0;
      in_buf_base   <= IN_BUF_BASE;
      out_buf_base  <= OUT_BUF_BASE;
    end
    else
    begin
      bm_in_enable  <= in_bme_reg;
      bm_out_enable <= out_bme_reg;
      in_buf_base   <= IN_BUF_BASE;
      out_buf_base  <= OUT_BUF_BASE;
    end
  end

endmodule

`default_nettype wire

// *** sim/usb_control_endpoint_zero_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module usb_control_endpoint_zero_regs_test
  import usbep0_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        rd_ph = 1'b0;
  wire         tok_setup, tok_in, in_host_ack, tok_out, out_data_ok;
  wire  [3:0]  out_len, in_len;
  wire         hreadyout, hresp, hs_valid, hs_is_in, data_toggle;
  wire         bm_in_enable, bm_out_enable, irq;
  wire  [31:0] hrdata;
  wire  [1:0]  hs_code;
  wire  [15:0] in_buf_base, out_buf_base;
  logic [1:0]  exp_hs[$];
  logic [31:0] exp_rd[$];
  logic [3:0]  len;
  int          failures = 0;
  int          checks_done = 0;
  logic [15:0] idx_tab[7] = '{IDX_IN_CFG, IDX_IN_CNT, IDX_OUT_CFG, IDX_OUT_CNT,
                              IDX_STATUS, IDX_MASK, 16'hff86};
  logic [7:0]  rst_tab[7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Clock
  always #5 clk = ~clk;

  usbep0_regs dut_u (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tok_setup(tok_setup),
    .tok_in(tok_in), .in_host_ack(in_host_ack), .tok_out(tok_out),
    .out_data_ok(out_data_ok), .out_len(out_len), .hs_valid(hs_valid),
    .hs_code(hs_code), .hs_is_in(hs_is_in), .in_len(in_len),
    .data_toggle(data_toggle), .bm_in_enable(bm_in_enable),
    .bm_out_enable(bm_out_enable), .in_buf_base(in_buf_base),
    .out_buf_base(out_buf_base), .irq(irq)
  );

  usbep0_host host_u (
    .clk(clk), .tok_setup(tok_setup), .tok_in(tok_in), .in_host_ack(in_host_ack),
    .tok_out(tok_out), .out_data_ok(out_data_ok), .out_len(out_len)
  );

  // ------------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task automatic print_verdict();
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Compare each answer and each read with the oldest note
  always @(posedge clk)
  begin
    if (hs_valid === 1'b1)
      check("hs_code", hs_code, exp_hs.size() ? exp_hs.pop_front() : 2'h3);
    if (rd_ph && hreadyout === 1'b1)
      check("hrdata", hrdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    rd_ph <= (htrans[1] && hreadyout && !hwrite) || (rd_ph && hreadyout !== 1'b1);
  end

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic wait_ready();
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
        failures++;
        print_verdict();
      end
    end
  endtask

  // Write d, or read and expect d
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    begin
      if (!wr)
        exp_rd.push_back({24'h0, d});
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {14'h0, idx, 2'h0};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
    end
  endtask

  task automatic tok(input int kind, input logic [1:0] code, input logic [3:0] n);
    begin
      if (kind != 3)
        exp_hs.push_back(code);
      host_u.send(kind, n);
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4bf971c2));
    repeat (2)
    begin
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 7; i++)
        bus(1'b0, idx_tab[i], rst_tab[i]);
      bus(1'b1, IDX_IN_CNT, 8'h0f);
      bus(1'b1, 16'hff86, 8'hff);
    end
    // Buffer back to empty after the count writes above
    bus(1'b1, IDX_IN_CNT, 8'h80);
    bus(1'b1, IDX_MASK, 8'h07);
    bus(1'b1, IDX_IN_CFG, 8'hff);
    bus(1'b0, IDX_IN_CFG, 8'h8c);
    bus(1'b1, IDX_IN_CFG, 8'h84);
    bus(1'b1, IDX_OUT_CFG, 8'h84);
    tok(1, HS_NAK, 4'h0);
    len = 4'($urandom_range(15, 9));
    bus(1'b1, IDX_IN_CNT, {4'h8, len});
    bus(1'b1, IDX_IN_CNT, {4'h0, len});
    check("in_len", in_len, 32'h8);
    check("bm_in", bm_in_enable, 32'h1);
    tok(1, HS_ACK, 4'h0);
    tok(3, HS_ACK, 4'h0);
    bus(1'b0, IDX_IN_CFG, 8'ha4);
    bus(1'b0, IDX_STATUS, 8'h01);
    check("irq", irq, 32'h1);
    bus(1'b1, IDX_MASK, 8'h06);
    repeat (2) @(posedge clk);
    check("irq", irq, 32'h0);
    bus(1'b1, IDX_STATUS, 8'h01);
    bus(1'b1, IDX_MASK, 8'h07);
    bus(1'b0, IDX_STATUS, 8'h00);
    // No interrupt with the enable off
    bus(1'b1, IDX_IN_CFG, 8'h80);
    bus(1'b1, IDX_IN_CNT, 8'h03);
    tok(1, HS_ACK, 4'h0);
    check("in_len", in_len, 32'h3);
    tok(3, HS_ACK, 4'h0);
    check("data_toggle", data_toggle, 32'h1);
    bus(1'b0, IDX_STATUS, 8'h00);
    bus(1'b0, IDX_IN_CFG, 8'h80);
    // Output packet, then a full buffer
    len = 4'($urandom_range(8));
    tok(2, HS_ACK, len);
    bus(1'b0, IDX_OUT_CNT, {4'h8, len});
    check("data_toggle", data_toggle, 32'h0);
    bus(1'b0, IDX_STATUS, 8'h02);
    bus(1'b0, IDX_OUT_CFG, 8'ha4);
    tok(2, HS_NAK, 4'h1);
    bus(1'b1, IDX_OUT_CNT, 8'h0f);
    bus(1'b0, IDX_OUT_CNT, {4'h0, len});
    bus(1'b1, IDX_STATUS, 8'h02);
    bus(1'b1, IDX_OUT_CFG, 8'h04);
    tok(2, HS_NAK, 4'h2);
    check("bm_out", bm_out_enable, 32'h0);
    bus(1'b1, IDX_OUT_CFG, 8'h8c);
    tok(2, HS_STALL, 4'h2);
    bus(1'b0, IDX_OUT_CFG, 8'ha4);
    tok(2, HS_ACK, 4'h8);
    bus(1'b0, IDX_OUT_CNT, 8'h88);
    // Input stall lasts until setup
    bus(1'b1, IDX_IN_CFG, 8'h8c);
    tok(1, HS_STALL, 4'h0);
    tok(1, HS_STALL, 4'h0);
    tok(0, HS_ACK, 4'h0);
    bus(1'b0, IDX_IN_CFG, 8'ha4);
    bus(1'b1, IDX_IN_CNT, 8'h02);
    bus(1'b1, IDX_OUT_CNT, 8'h00);
    tok(1, HS_NAK, 4'h0);
    tok(2, HS_NAK, 4'h1);
    bus(1'b0, IDX_STATUS, 8'h06);
    bus(1'b1, IDX_STATUS, 8'h07);
    tok(1, HS_ACK, 4'h0);
    tok(2, HS_ACK, 4'h4);
    for (int n = 0; n < 20 && (exp_hs.size() || exp_rd.size()); n++)
      @(posedge clk);
    if (exp_hs.size() || exp_rd.size())
      failures++;
    print_verdict();
  end
endmodule

`default_nettype wire

// *** sim/usbep0_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module usbep0_host
(
  // Clock
  input  wire logic clk,
  // Tokens toward the endpoint
  output logic       tok_setup,
  output logic       tok_in,
  output logic       in_host_ack,
  output logic       tok_out,
  output logic       out_data_ok,
  output logic [3:0] out_len
);
  // Idle link
  initial
  begin
    tok_setup = 1'b0;
    tok_in = 1'b0;
    in_host_ack = 1'b0;
    tok_out = 1'b0;
    out_data_ok = 1'b0;
    out_len = 4'h0;
  end

  // One token pulse after a random host delay; kind 0 setup, 1 in, 2 out, 3 ack
  task automatic send(input int kind, input logic [3:0] len);
    begin
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk);
      tok_setup <= (kind == 0);
      tok_in <= (kind == 1);
      tok_out <= (kind == 2);
      in_host_ack <= (kind == 3);
      out_data_ok <= 1'b1;
      out_len <= len;
      @(posedge clk);
      tok_setup <= 1'b0;
      tok_in <= 1'b0;
      tok_out <= 1'b0;
      in_host_ack <= 1'b0;
      // Released data lines never keep a stale copy
      out_data_ok <= 1'b0;
      out_len <= ~len;
    end
  endtask
endmodule

`default_nettype wire

// *** sim/usbep0_regs_properties.sv ***
`timescale 1ns/1ns
`default_nettype none

module usbep0_regs_properties
  import usbep0_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Link
  input wire logic        tok_setup,
  input wire logic        tok_in,
  input wire logic        tok_out,
  input wire logic        hs_valid,
  input wire logic [1:0]  hs_code,
  input wire logic        hs_is_in,
  input wire logic [3:0]  in_len,
  input wire logic [15:0] in_buf_base,
  input wire logic [15:0] out_buf_base,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------------
  // Link answers
  // ------------------------------------------------------------------
  a_answer_one_cycle: assert property (hs_valid == $past(tok_setup | tok_in | tok_out))
    else $error("answer strobe not one cycle after token");
  a_setup_acked: assert property (tok_setup |=> hs_code == HS_ACK && !hs_is_in)
    else $error("setup not acknowledged");
  a_in_direction: assert property (tok_in |=> hs_is_in)
    else $error("in answer not marked as in");
  a_out_direction: assert property (tok_out |=> !hs_is_in)
    else $error("out answer marked as in");
  a_code_holds: assert property (!(tok_setup | tok_in | tok_out) |=> $stable(hs_code))
    else $error("answer code moved without token");
  a_fixed_bases: assert property (in_buf_base == IN_BUF_BASE && out_buf_base == OUT_BUF_BASE)
    else $error("buffer base moved");
  a_count_clamped: assert property (in_len <= CNT_MAX)
    else $error("in length above eight");

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  a_okay_only: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_one_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_no_wait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");

  // Main scenarios
  c_in_stall: cover property (tok_in ##1 hs_code == HS_STALL);
  c_out_ack: cover property (tok_out ##1 hs_code == HS_ACK);
  c_irq_rise: cover property ($rose(irq));
endmodule

bind usbep0_regs usbep0_regs_properties chk_u (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tok_setup(tok_setup),
  .tok_in(tok_in), .tok_out(tok_out), .hs_valid(hs_valid), .hs_code(hs_code),
  .hs_is_in(hs_is_in), .in_len(in_len), .in_buf_base(in_buf_base),
  .out_buf_base(out_buf_base), .irq(irq)
);

`default_nettype wire
